//--- design/fcl_pkg.sv
// Constants, codes and register map of the frequency command limiter.
// Assumes frequencies in 0.1 Hz steps and voltages in 1 V steps.
package fcl_pkg;

    // Frequency and voltage limits and special codes (0.1 Hz and 1 V units).
    localparam logic [15:0] F_400      = 16'h0FA0;
    localparam logic [15:0] F_120      = 16'h04B0;
    localparam logic [15:0] CODE_NONE  = 16'h270F;
    localparam logic [15:0] CODE_95    = 16'h22B8;
    localparam logic [15:0] V_1000     = 16'h03E8;

    // Reset values.
    localparam logic [15:0] UPPER_RST  = 16'h04B0;
    localparam logic [15:0] LOWER_RST  = 16'h0000;
    localparam logic [15:0] HS_RST     = 16'h04B0;
    localparam logic [15:0] START_RST  = 16'h0005;
    localparam logic [15:0] JOG_RST    = 16'h0032;
    localparam logic [15:0] BASE_RST   = 16'h0258;
    localparam logic [15:0] RVOLT_RST  = 16'h00C8;
    localparam logic [15:0] RFREQ_RST  = 16'h0258;
    localparam logic [15:0] STEP_RST   = 16'h0001;
    localparam logic [7:0]  BYTE_RST   = 8'h00;

    // Selection codes.
    localparam logic [7:0]  TSEL_SECOND = 8'h03;
    localparam logic [7:0]  PAT_S_A     = 8'h01;
    localparam logic [7:0]  EXT_ALL     = 8'h00;

    // Supply percentage for the 95 percent code.
    localparam logic [17:0] PCT_NUM    = 18'h0005F;
    localparam logic [17:0] PCT_DEN    = 18'h00064;

    // Ramp tick period.
    localparam int unsigned TICK_US    = 1000;
    localparam int unsigned CLK_MHZ    = 40;

    // Register byte offsets.
    localparam logic [11:0] OFF_UPPER  = 12'h000;
    localparam logic [11:0] OFF_LOWER  = 12'h004;
    localparam logic [11:0] OFF_HS     = 12'h008;
    localparam logic [11:0] OFF_START  = 12'h00C;
    localparam logic [11:0] OFF_JOG    = 12'h010;
    localparam logic [11:0] OFF_SKIP   = 12'h014;
    localparam logic [11:0] OFF_BASE   = 12'h02C;
    localparam logic [11:0] OFF_BVOLT  = 12'h030;
    localparam logic [11:0] OFF_SEC    = 12'h034;
    localparam logic [11:0] OFF_TSEL   = 12'h038;
    localparam logic [11:0] OFF_RVOLT  = 12'h04C;
    localparam logic [11:0] OFF_RFREQ  = 12'h050;
    localparam logic [11:0] OFF_PAT    = 12'h054;
    localparam logic [11:0] OFF_EXT    = 12'h058;
    localparam logic [11:0] OFF_CTRL   = 12'h05C;
    localparam logic [11:0] OFF_STEP   = 12'h060;
    localparam logic [11:0] OFF_TGT    = 12'h064;
    localparam logic [11:0] OFF_RUN    = 12'h068;
    localparam logic [11:0] OFF_VOLT   = 12'h06C;
    localparam logic [11:0] OFF_STAT   = 12'h070;

    typedef enum logic [1:0] {
        DIV_IDLE = 2'b00,
        DIV_RUN  = 2'b01,
        DIV_DONE = 2'b10
    } fcl_div_e;

endpackage

//--- design/fcl_top.sv
// Frequency command limiter with skip zones, ramp and V/F reference.
// Assumes one 40 MHz clock, an APB master and synchronous inputs.
//
// Overview of operation
// RL1: Clamp output at upper limit, default 120Hz.
// RL2: High-speed upper limit 120 to 400Hz.
// RL3: Writing either upper limit copies to other.
// RL4: Clamp output at lower limit, default 0Hz.
// RL5: Jog at or below lower limit bypasses it.
// RL6: Stall reduction may go below lower limit.
// RL7: Lower limit above start freq runs without command.
// RL8: Six skip boundaries, 9999 disables, default 9999.
// RL9: Three zones; either boundary may be top.
// RL10: Command inside zone runs at A boundary.
// RL11: Ramping frequency passes through skip zones.
// RL12: Base frequency 0 to 400Hz, default 60Hz.
// RL13: Base voltage codes 8888 and 9999 supported.
// RL14: Second base frequency used while input asserted.
// RL15: Second input needs terminal function code 3.
// RL16: Base voltage below supply caps output voltage.
// RL17: Vector mode uses rated motor voltage, frequency.
// RL18: S-curve A uses active base as inflection.
// RL19: Extended settings writable only when display is 0.
// RL20: All sources pass clamps and skip zones; a jog at or below the lower limit skips the lower clamp.
//
// The implementer's own choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
module fcl_top import fcl_pkg::*; #(
    parameter int unsigned TICK_CYCLES = TICK_US * CLK_MHZ,
    parameter int unsigned NZONE       = 3,
    parameter int unsigned NTERM       = 5
) (
    // Clock and reset
    input  wire logic              CLK,
    input  wire logic              RST_N,
    // APB slave
    input  wire logic              PSEL,
    input  wire logic              PENABLE,
    input  wire logic              PWRITE,
    input  wire logic [11:0]       PADDR,
    input  wire logic [31:0]       PWDATA,
    output logic      [31:0]       PRDATA,
    output logic                   PREADY,
    output logic                   PSLVERR,
    // Command side
    input  wire logic [15:0]       FREQ_CMD,
    input  wire logic              CMD_VALID,
    input  wire logic              START,
    input  wire logic              JOG,
    input  wire logic              STALL_REDUCE,
    input  wire logic [NTERM-1:0]  TERM_IN,
    input  wire logic [15:0]       SUPPLY_VOLT,
    input  wire logic              SINGLE_100V,
    // Output stage
    output logic      [15:0]       TARGET_FREQ,
    output logic      [15:0]       RUN_FREQ,
    output logic      [15:0]       VOLT_REF,
    output logic      [15:0]       BASE_ACTIVE,
    output logic                   S_CURVE_A,
    output logic                   RAMPING
);

    localparam int unsigned TW = $clog2(TICK_CYCLES);
    localparam int unsigned NB = 24;

    if (NZONE < 1 || NZONE > 3) begin : g_bad_zone
        $error("NZONE must be 1 to 3");
    end
    if (NTERM < 1 || NTERM > 5) begin : g_bad_term
        $error("NTERM must be 1 to 5");
    end
    if (TICK_CYCLES < 2) begin : g_bad_tick
        $error("TICK_CYCLES must be at least 2");
    end

    typedef struct packed {
        logic [15:0]             upper;
        logic [15:0]             lower;
        logic [15:0]             hs;
        logic [15:0]             start;
        logic [15:0]             jog;
        logic [2*NZONE-1:0][15:0] skip;
        logic [15:0]             base;
        logic [15:0]             bvolt;
        logic [15:0]             sec;
        logic [NTERM-1:0][7:0]   tsel;
        logic [15:0]             rvolt;
        logic [15:0]             rfreq;
        logic [7:0]              pat;
        logic [7:0]              ext;
        logic                    vec;
        logic [15:0]             step;
        logic [TW-1:0]           tick;
        logic [15:0]             tgt;
        logic [15:0]             run;
        logic [15:0]             bact;
        logic [15:0]             volt;
        logic [15:0]             vcap;
        logic [15:0]             den;
        logic [NB-1:0]           num;
        logic [NB-1:0]           quo;
        logic [16:0]             rem;
        logic [4:0]              cnt;
        fcl_div_e                st;
        logic [31:0]             prdata;
        logic                    err;
    } fcl_state_s;

    fcl_state_s q;
    fcl_state_s d;

    // Per-terminal second-function decode and per-zone hit detection.
    logic [NTERM-1:0] rt_vec;
    logic [NZONE-1:0] hit;
    logic [15:0]      stage;

    for (genvar i = 0; i < NTERM; i++) begin : g_term
        assign rt_vec[i] = (q.tsel[i] == TSEL_SECOND) && TERM_IN[i]; // RL15
    end

    for (genvar z = 0; z < NZONE; z++) begin : g_zone
        logic [15:0] za;
        logic [15:0] zb;
        logic [15:0] lo;
        logic [15:0] hi;
        assign za = q.skip[2*z];
        assign zb = q.skip[2*z+1];
        assign lo = (za < zb) ? za : zb; // RL9
        assign hi = (za < zb) ? zb : za; // RL9
        assign hit[z] = (za != CODE_NONE) && (zb != CODE_NONE) // RL8
                        && (stage >= lo) && (stage <= hi);
    end

    always_comb begin
        logic        rt;
        logic        wen;
        logic        ok;
        logic        hitreg;
        logic        prot;
        logic [15:0] wv;
        logic [31:0] rd;
        logic [15:0] raw;
        logic [15:0] sk;
        logic [16:0] seff;
        logic [17:0] pct;
        logic [16:0] vlim;
        logic [16:0] r2;
        logic [31:0] prod;
        rt     = |rt_vec;
        wen    = PSEL && PENABLE && PWRITE && !q.err;
        ok     = (PWDATA[31:16] == 16'h0000);
        hitreg = 1'b1;
        prot   = 1'b0;
        wv     = PWDATA[15:0];
        rd     = 32'h0000_0000;
        d      = q;
        raw    = 16'h0000;
        sk     = 16'h0000;
        seff   = 17'h0_0000;
        pct    = 18'h0_0000;
        vlim   = 17'h0_0000;
        r2     = 17'h0_0000;
        prod   = 32'h0000_0000;

        // Register decode: read value, range check and write action.
        if (PADDR == OFF_UPPER) begin
            rd = {16'h0000, q.upper};
            ok = ok && (wv <= F_120); // RL1
            if (wen) begin
                d.upper = wv;
                d.hs    = wv; // RL3
            end
        end else if (PADDR == OFF_LOWER) begin
            rd = {16'h0000, q.lower};
            ok = ok && (wv <= F_120); // RL4
            if (wen) begin
                d.lower = wv;
            end
        end else if (PADDR == OFF_HS) begin
            rd   = {16'h0000, q.hs};
            prot = 1'b1;
            ok   = ok && (wv >= F_120) && (wv <= F_400); // RL2
            if (wen) begin
                d.hs    = wv;
                d.upper = wv; // RL3
            end
        end else if (PADDR == OFF_START) begin
            rd = {16'h0000, q.start};
            ok = ok && (wv <= F_400);
            if (wen) begin
                d.start = wv;
            end
        end else if (PADDR == OFF_JOG) begin
            rd = {16'h0000, q.jog};
            ok = ok && (wv <= F_400);
            if (wen) begin
                d.jog = wv;
            end
        end else if (PADDR >= OFF_SKIP
                     && PADDR < OFF_SKIP + 12'(8 * NZONE)) begin
            rd   = 32'h0000_0000;
            prot = 1'b1;
            ok   = ok && ((wv <= F_400) || (wv == CODE_NONE)); // RL8
            for (int k = 0; k < 2 * NZONE; k++) begin
                if (PADDR == OFF_SKIP + 12'(4 * k)) begin
                    rd = {16'h0000, q.skip[k]};
                    if (wen) begin
                        d.skip[k] = wv;
                    end
                end
            end
        end else if (PADDR == OFF_BASE) begin
            rd = {16'h0000, q.base};
            ok = ok && (wv <= F_400); // RL12
            if (wen) begin
                d.base = wv;
            end
        end else if (PADDR == OFF_BVOLT) begin
            rd   = {16'h0000, q.bvolt};
            prot = 1'b1;
            ok   = ok && ((wv <= V_1000) || (wv == CODE_95)
                          || (wv == CODE_NONE)); // RL13
            if (wen) begin
                d.bvolt = wv;
            end
        end else if (PADDR == OFF_SEC) begin
            rd   = {16'h0000, q.sec};
            prot = 1'b1;
            ok   = ok && ((wv <= F_400) || (wv == CODE_NONE)); // RL14
            if (wen) begin
                d.sec = wv;
            end
        end else if (PADDR >= OFF_TSEL
                     && PADDR < OFF_TSEL + 12'(4 * NTERM)) begin
            ok = ok && (PWDATA[15:8] == 8'h00);
            for (int k = 0; k < NTERM; k++) begin
                if (PADDR == OFF_TSEL + 12'(4 * k)) begin
                    rd = {24'h00_0000, q.tsel[k]};
                    if (wen) begin
                        d.tsel[k] = PWDATA[7:0];
                    end
                end
            end
        end else if (PADDR == OFF_RVOLT) begin
            rd = {16'h0000, q.rvolt};
            ok = ok && (wv <= V_1000);
            if (wen) begin
                d.rvolt = wv;
            end
        end else if (PADDR == OFF_RFREQ) begin
            rd = {16'h0000, q.rfreq};
            ok = ok && (wv <= F_400);
            if (wen) begin
                d.rfreq = wv;
            end
        end else if (PADDR == OFF_PAT) begin
            rd = {24'h00_0000, q.pat};
            ok = ok && (PWDATA[15:8] == 8'h00);
            if (wen) begin
                d.pat = PWDATA[7:0];
            end
        end else if (PADDR == OFF_EXT) begin
            rd = {24'h00_0000, q.ext};
            ok = ok && (PWDATA[15:8] == 8'h00);
            if (wen) begin
                d.ext = PWDATA[7:0];
            end
        end else if (PADDR == OFF_CTRL) begin
            rd = {31'h0000_0000, q.vec};
            ok = ok && (PWDATA[15:1] == 15'h0000);
            if (wen) begin
                d.vec = PWDATA[0];
            end
        end else if (PADDR == OFF_STEP) begin
            rd = {16'h0000, q.step};
            if (wen) begin
                d.step = wv;
            end
        end else if (PADDR == OFF_TGT) begin
            rd = {16'h0000, q.tgt};
            ok = 1'b0;
        end else if (PADDR == OFF_RUN) begin
            rd = {16'h0000, q.run};
            ok = 1'b0;
        end else if (PADDR == OFF_VOLT) begin
            rd = {16'h0000, q.volt};
            ok = 1'b0;
        end else if (PADDR == OFF_STAT) begin
            rd = {28'h000_0000, q.vec, |hit, rt, q.run != q.tgt};
            ok = 1'b0;
        end else begin
            hitreg = 1'b0;
            ok     = 1'b0;
        end

        // Setup phase latches read data and the error answer.
        if (PSEL && !PENABLE) begin
            d.prdata = hitreg ? rd : 32'h0000_0000;
            d.err    = !hitreg || (PWRITE && (!ok
                       || (prot && q.ext != EXT_ALL))); // RL19
        end

        // Command conditioning shared by every source.
        raw = JOG ? q.jog : (CMD_VALID ? FREQ_CMD : 16'h0000); // RL20
        if (raw > q.upper) begin
            stage = q.upper; // RL1
        end else if (raw < q.lower && !(JOG && q.jog <= q.lower)) begin
            stage = q.lower; // RL4
        end else begin
            stage = raw; // RL5
        end
        sk = stage;
        for (int z = NZONE - 1; z >= 0; z--) begin
            if (hit[z]) begin
                sk = q.skip[2*z]; // RL10
            end
        end
        if (!START) begin
            d.tgt = 16'h0000;
        end else if (!JOG && sk < q.start) begin
            d.tgt = 16'h0000; // RL7
        end else begin
            d.tgt = sk; // RL7
        end

        // Ramp toward the steady target, crossing skip zones freely.
        d.tick = (q.tick == TW'(TICK_CYCLES - 1)) ? '0 : q.tick + 1'b1;
        if (q.tick == TW'(TICK_CYCLES - 1)) begin
            if (STALL_REDUCE) begin
                d.run = (q.run > q.step) ? q.run - q.step : 16'h0000; // RL6
            end else if (q.run < q.tgt) begin
                d.run = (q.tgt - q.run > q.step) ? q.run + q.step
                                                 : q.tgt; // RL11
            end else if (q.run > q.tgt) begin
                d.run = (q.run - q.tgt > q.step) ? q.run - q.step
                                                 : q.tgt; // RL11
            end
        end

        // Active base point and voltage ceiling.
        if (q.vec) begin
            d.bact = q.rfreq; // RL17
        end else if (rt && q.sec != CODE_NONE) begin
            d.bact = q.sec; // RL14
        end else begin
            d.bact = q.base; // RL12
        end
        seff = SINGLE_100V ? {SUPPLY_VOLT, 1'b0} : {1'b0, SUPPLY_VOLT};
        pct  = ({1'b0, seff} * PCT_NUM) / PCT_DEN;
        if (q.bvolt == CODE_NONE) begin
            vlim = seff; // RL13
        end else if (q.bvolt == CODE_95) begin
            vlim = pct[16:0]; // RL13
        end else if ({1'b0, q.bvolt} < seff) begin
            vlim = {1'b0, q.bvolt}; // RL16
        end else begin
            vlim = seff;
        end
        if (q.vec) begin
            vlim = {1'b0, q.rvolt}; // RL17
        end

        // Voltage reference: ceiling scaled by run over base point.
        r2   = {q.rem[15:0], q.num[NB-1]};
        prod = 32'h0000_0000;
        case (q.st)
            DIV_IDLE: begin
                d.vcap = vlim[16] ? 16'hFFFF : vlim[15:0];
                prod   = d.vcap * q.run;
                d.den  = q.bact;
                d.num  = prod[NB-1:0];
                d.rem  = 17'h0_0000;
                d.quo  = '0;
                d.cnt  = 5'(NB - 1);
                if (q.bact == 16'h0000 || prod[31:NB] != '0) begin
                    d.volt = d.vcap;
                end else begin
                    d.st = DIV_RUN;
                end
            end
            DIV_RUN: begin
                d.num = {q.num[NB-2:0], 1'b0};
                if (r2 >= {1'b0, q.den}) begin
                    d.rem = r2 - {1'b0, q.den};
                    d.quo = {q.quo[NB-2:0], 1'b1};
                end else begin
                    d.rem = r2;
                    d.quo = {q.quo[NB-2:0], 1'b0};
                end
                d.cnt = q.cnt - 1'b1;
                if (q.cnt == 5'h00) begin
                    d.st = DIV_DONE;
                end
            end
            DIV_DONE: begin
                d.volt = (q.quo > NB'(q.vcap)) ? q.vcap : q.quo[15:0];
                d.st   = DIV_IDLE;
            end
            default: begin
                d.st = DIV_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            q        <= '0;
            q.upper  <= UPPER_RST;
            q.lower  <= LOWER_RST;
            q.hs     <= HS_RST;
            q.start  <= START_RST;
            q.jog    <= JOG_RST;
            q.skip   <= {(2 * NZONE){CODE_NONE}}; // RL8
            q.base   <= BASE_RST;
            q.bvolt  <= CODE_NONE;
            q.sec    <= CODE_NONE;
            q.tsel   <= {NTERM{BYTE_RST}};
            q.rvolt  <= RVOLT_RST;
            q.rfreq  <= RFREQ_RST;
            q.pat    <= BYTE_RST;
            q.ext    <= EXT_ALL;
            q.step   <= STEP_RST;
            q.bact   <= BASE_RST;
            q.st     <= DIV_IDLE;
        end else begin
            q <= d;
        end
    end

    assign PREADY      = PSEL && PENABLE;
    assign PRDATA      = q.prdata;
    assign PSLVERR     = PSEL && PENABLE && q.err;
    assign TARGET_FREQ = q.tgt;
    assign RUN_FREQ    = q.run;
    assign VOLT_REF    = q.volt;
    assign BASE_ACTIVE = q.bact; // RL18
    assign S_CURVE_A   = (q.pat == PAT_S_A); // RL18
    assign RAMPING     = (q.run != q.tgt);

endmodule // fcl_top

//--- tb/fcl_chk_assertions.sv
// Port-level assertions for the frequency command limiter.
// Assumes a bind into fcl_top and a 4-cycle ramp tick.
`timescale 1ns/1ps
module fcl_chk import fcl_pkg::*; #(
    parameter int unsigned TICK_CYCLES = 4,
    parameter int unsigned NTERM       = 5
) (
    // Clock and reset
    input wire logic             CLK,
    input wire logic             RST_N,
    // APB
    input wire logic             PSEL,
    input wire logic             PENABLE,
    input wire logic             PWRITE,
    input wire logic [11:0]      PADDR,
    input wire logic [31:0]      PWDATA,
    input wire logic [31:0]      PRDATA,
    input wire logic             PREADY,
    input wire logic             PSLVERR,
    // Command side
    input wire logic [15:0]      FREQ_CMD,
    input wire logic             CMD_VALID,
    input wire logic             START,
    input wire logic             JOG,
    input wire logic             STALL_REDUCE,
    input wire logic [NTERM-1:0] TERM_IN,
    input wire logic [15:0]      SUPPLY_VOLT,
    input wire logic             SINGLE_100V,
    // Output stage
    input wire logic [15:0]      TARGET_FREQ,
    input wire logic [15:0]      RUN_FREQ,
    input wire logic [15:0]      VOLT_REF,
    input wire logic [15:0]      BASE_ACTIVE,
    input wire logic             S_CURVE_A,
    input wire logic             RAMPING
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);
    sequence stall_hold;
        (STALL_REDUCE && RUN_FREQ != 16'h0000) [*5];
    endsequence
    sequence pat_write;
        PSEL && PENABLE && PWRITE && !PSLVERR && PADDR == OFF_PAT;
    endsequence
    pready_match_a: assert property (PREADY == (PSEL && PENABLE))
        else $error("ready not equal to access phase");
    unmapped_err_a: assert property (PSEL && PENABLE && PADDR == 12'h0FC
        |-> PSLVERR && PRDATA == 32'h0) else $error("unmapped not refused");
    ro_write_a: assert property (PSEL && PENABLE && PWRITE
        && PADDR == OFF_TGT |-> PSLVERR) else $error("read-only write taken");
    target_ceil_a: assert property (TARGET_FREQ <= F_400)
        else $error("target above ceiling");
    run_ceil_a: assert property (RUN_FREQ <= F_400)
        else $error("run above ceiling");
    start_off_a: assert property (!START && !JOG |=> TARGET_FREQ == 16'h0)
        else $error("target without start");
    ramp_flag_a: assert property (RAMPING == (RUN_FREQ != TARGET_FREQ))
        else $error("ramping flag wrong");
    stall_drop_a: assert property (stall_hold
        |-> RUN_FREQ < $past(RUN_FREQ, 4))
        else $error("stall no drop");
    scurve_follow_a: assert property (pat_write
        |=> S_CURVE_A == ($past(PWDATA) == 32'h1))
        else $error("s-curve flag wrong");
endmodule // fcl_chk

bind fcl_top fcl_chk #(.TICK_CYCLES(TICK_CYCLES), .NTERM(NTERM)) u_chk (.*);

//--- tb/fcl_src_model.sv
// Command source and supply feeding the limiter.
// Assumes its tasks are called from the bench's main sequence.
`timescale 1ns/1ps
module fcl_src_model (
    // Clock
    input  wire logic  clk,
    // Toward the limiter
    output logic [15:0] freq_cmd,
    output logic        cmd_valid,
    output logic        start,
    output logic        jog,
    output logic        stall_reduce,
    output logic [4:0]  term_in,
    output logic [15:0] supply_volt,
    output logic        single_100v
);
    initial begin
        freq_cmd = 16'h0000;
        cmd_valid = 1'b0;
        start = 1'b0;
        jog = 1'b0;
        stall_reduce = 1'b0;
        term_in = 5'h00;
        supply_volt = 16'h00C8;
        single_100v = 1'b0;
    end
    // An absent command leaves junk on the bus, not the last value.
    task automatic drive(input logic [15:0] f, input logic v, s, j, st);
        @(posedge clk);
        freq_cmd <= v ? f : ~freq_cmd;
        cmd_valid <= v;
        start <= s;
        jog <= j;
        stall_reduce <= st;
    endtask
    task automatic pins(input logic [4:0] t, input logic [15:0] sv,
                        input logic one);
        @(posedge clk);
        term_in <= t;
        supply_volt <= sv;
        single_100v <= one;
    endtask
endmodule // fcl_src_model

//--- tb/tb.sv
// Self-checking bench for the frequency command limiter.
// Assumes the checker is bound into fcl_top by its own file.
`timescale 1ns/1ps
module tb import fcl_pkg::*;;
    logic        CLK = 1'b0;
    logic        RST_N = 1'b0;
    logic        PSEL = 1'b0;
    logic        PENABLE = 1'b0;
    logic        PWRITE = 1'b0;
    logic [11:0] PADDR = 12'h000;
    logic [31:0] PWDATA = 32'h0;
    logic [31:0] PRDATA, rdat;
    logic        PREADY, PSLVERR, perr, CMD_VALID, START, JOG;
    logic        STALL_REDUCE, SINGLE_100V, S_CURVE_A, RAMPING;
    logic [15:0] FREQ_CMD, SUPPLY_VOLT, TARGET_FREQ, RUN_FREQ;
    logic [15:0] VOLT_REF, BASE_ACTIVE;
    logic [4:0]  TERM_IN;
    logic [15:0] bv [4] = '{CODE_NONE, CODE_95, 16'h0096, CODE_NONE};
    logic [15:0] ev [4] = '{16'h00C8, 16'h00BE, 16'h0096, 16'h0190};
    int          bad_count = 0;
    int          n_checks = 0;

    always #12.5 CLK = ~CLK;

    fcl_top #(.TICK_CYCLES(4)) u_dut (.*);

    fcl_src_model u_src (
        .clk(CLK), .freq_cmd(FREQ_CMD), .cmd_valid(CMD_VALID),
        .start(START), .jog(JOG), .stall_reduce(STALL_REDUCE),
        .term_in(TERM_IN), .supply_volt(SUPPLY_VOLT),
        .single_100v(SINGLE_100V));

    task automatic chk(input string nm, input logic [31:0] got, exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge CLK);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLK);
        PENABLE <= 1'b1;
        do @(posedge CLK); while (PREADY !== 1'b1);
        rdat = PRDATA;
        perr = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rchk(input string nm, input logic [11:0] a,
                        input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(nm, rdat, exp);
    endtask
    task automatic go(input logic [15:0] f, input logic v, s, j, st);
        u_src.drive(f, v, s, j, st);
        repeat (4) @(posedge CLK);
    endtask
    task automatic wait_run(input logic [15:0] v);
        for (int i = 0; i < 3000 && RUN_FREQ !== v; i++) @(posedge CLK);
        chk("run", RUN_FREQ, v);
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge CLK);
        bad_count++;
        print_verdict;
    end

    initial begin
        repeat (12) @(posedge CLK);
        RST_N <= 1'b1;
        rchk("upper", OFF_UPPER, 32'h04B0);
        rchk("lower", OFF_LOWER, 32'h0000);
        rchk("hs", OFF_HS, 32'h04B0);
        for (int k = 0; k < 6; k++) begin
            rchk("skip", OFF_SKIP + 12'(4 * k), CODE_NONE);
        end
        rchk("base", OFF_BASE, 32'h0258);
        rchk("bvolt", OFF_BVOLT, CODE_NONE);
        rchk("second", OFF_SEC, CODE_NONE);
        rchk("unmapped", 12'h0FC, 32'h0);
        chk("unmapped err", {31'h0, perr}, 32'h1);
        wr(OFF_UPPER, 32'h03E8);
        rchk("hs copy", OFF_HS, 32'h03E8);
        wr(OFF_HS, 32'h07D0);
        rchk("upper copy", OFF_UPPER, 32'h07D0);
        apb(1'b1, OFF_UPPER, 32'h0514);
        chk("range err", {31'h0, perr}, 32'h1);
        wr(OFF_EXT, 32'h1);
        apb(1'b1, OFF_HS, 32'h0BB8);
        chk("locked err", {31'h0, perr}, 32'h1);
        wr(OFF_EXT, 32'h0);
        rchk("hs kept", OFF_HS, 32'h07D0);
        wr(OFF_UPPER, 32'h03E8);
        go(16'h044C, 1'b1, 1'b1, 1'b0, 1'b0);
        chk("clamp high", TARGET_FREQ, 32'h03E8);
        wr(OFF_LOWER, 32'h00C8);
        go(16'h0064, 1'b1, 1'b1, 1'b0, 1'b0);
        chk("clamp low", TARGET_FREQ, 32'h00C8);
        go(16'h0064, 1'b0, 1'b1, 1'b0, 1'b0);
        chk("no command", TARGET_FREQ, 32'h00C8);
        go(16'h0064, 1'b0, 1'b1, 1'b1, 1'b0);
        chk("jog", TARGET_FREQ, JOG_RST);
        wr(OFF_SKIP, 32'h012C);
        wr(OFF_SKIP + 12'h004, 32'h00FA);
        wr(OFF_SKIP + 12'h008, 32'h0190);
        wr(OFF_SKIP + 12'h00C, 32'h01C2);
        go(16'h010E, 1'b1, 1'b1, 1'b0, 1'b0);
        chk("zone top a", TARGET_FREQ, 32'h012C);
        go(16'h01AE, 1'b1, 1'b1, 1'b0, 1'b0);
        chk("zone low a", TARGET_FREQ, 32'h0190);
        go(16'h012C, 1'b1, 1'b0, 1'b0, 1'b0);
        wait_run(16'h0000);
        go(16'h012C, 1'b1, 1'b1, 1'b0, 1'b0);
        wait_run(16'h010E);
        wait_run(16'h012C);
        wr(OFF_BASE, 32'h012C);
        for (int k = 0; k < 4; k++) begin
            wr(OFF_BVOLT, {16'h0, bv[k]});
            u_src.pins(5'h00, 16'h00C8, k == 3);
            repeat (60) @(posedge CLK);
            chk("volt", VOLT_REF, ev[k]);
        end
        go(16'h012C, 1'b1, 1'b1, 1'b0, 1'b1);
        wait_run(16'h00BE);
        go(16'h012C, 1'b1, 1'b1, 1'b0, 1'b0);
        wr(OFF_BASE, 32'h0258);
        wr(OFF_SEC, 32'h01F4);
        u_src.pins(5'h04, 16'h00C8, 1'b0);
        repeat (4) @(posedge CLK);
        chk("base unmapped", BASE_ACTIVE, 32'h0258);
        wr(OFF_TSEL + 12'h008, 32'h3);
        repeat (4) @(posedge CLK);
        chk("second base", BASE_ACTIVE, 32'h01F4);
        wr(OFF_CTRL, 32'h1);
        wr(OFF_RFREQ, 32'h0226);
        repeat (4) @(posedge CLK);
        chk("vector base", BASE_ACTIVE, 32'h0226);
        wr(OFF_CTRL, 32'h0);
        wr(OFF_PAT, 32'h1);
        repeat (2) @(posedge CLK);
        chk("s curve", {31'h0, S_CURVE_A}, 32'h1);
        chk("inflection", BASE_ACTIVE, 32'h01F4);
        wr(OFF_PAT, 32'h0);
        repeat (2) @(posedge CLK);
        chk("s curve off", {31'h0, S_CURVE_A}, 32'h0);
        apb(1'b1, OFF_TGT, 32'h0);
        chk("ro err", {31'h0, perr}, 32'h1);
        print_verdict;
    end
endmodule // tb
